/* File: hw/ebc_bus_control.sv */
// expansion bus control signals of the board: buffers, float, reset pulse
// assumes processor strobes are on i_clock; bus inputs are asynchronous
`timescale 1ns/1ns
module ebc_bus_control
  import ebc_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = EBC_RESET_CYCLES
)(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_cpu_read_write,
  input wire logic i_cpu_sync,
  input wire logic i_phase1,
  input wire logic i_cpu_read_cycle,
  input wire logic i_onboard_selected,
  input wire logic i_bank_select_ctrl_bit,
  input wire logic i_dma_terminate_ctrl_bit,
  input wire logic i_reset_button,
  input wire logic i_bus_set_overflow,
  input wire logic i_bus_ready_in,
  input wire logic i_bus_float_request_n,
  input wire logic i_bus_irq_n,
  input wire logic i_bus_nmi_n,
  output logic o_bus_read_not_write_n,
  output logic o_bus_read_not_write_n_oe,
  output logic o_bus_opcode_fetch_sync,
  output logic o_bus_opcode_fetch_sync_oe,
  output logic o_bank_select_n,
  output logic o_bank_select_n_oe,
  output logic o_address_oe,
  output logic o_data_oe,
  output logic o_phase1_out,
  output logic o_dma_terminate_n,
  output logic o_bus_reset_n,
  output logic o_cpu_set_overflow,
  output logic o_cpu_halt,
  output logic o_irq_bus_source,
  output logic o_cpu_nmi_n,
  output logic o_dma_active
);
  // the stretch counter needs at least two counts to give a visible pulse
  if (RESET_CYCLES < 2) begin : g_bad_reset_cycles
    $error("RESET_CYCLES too small");
  end

  ebc_sync_if sync_bus ();

  ebc_input_sync u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_reset_button, i_bus_nmi_n, i_bus_irq_n, i_bus_float_request_n,
      i_bus_set_overflow, i_bus_ready_in}),
    .sync_out(sync_bus)
  );

  logic floating;
  assign floating = ~sync_bus.float_n;

  // output buffers and overflow edge detect
  logic rnw_reg, rnw_next;
  logic syncout_reg, syncout_next;
  logic bank_reg, bank_next;
  logic dmat_reg, dmat_next;
  logic so_prev_reg, so_prev_next;
  logic sov_reg, sov_next;
  logic halt_reg, halt_next;
  logic irq_reg, irq_next;
  logic nmi_reg, nmi_next;
  logic fl_reg, fl_next;
  logic data_reg, data_next;

  always_comb begin
    rnw_next = ~i_cpu_read_write;
    // sync raised in phase one of a fetch and held to cycle end
    if (i_cpu_sync && i_phase1) begin
      syncout_next = 1'b1;
    end else if (i_phase1) begin
      syncout_next = 1'b0;
    end else begin
      syncout_next = syncout_reg;
    end
    bank_next = ~i_bank_select_ctrl_bit;
    dmat_next = ~i_dma_terminate_ctrl_bit;
    so_prev_next = sync_bus.set_overflow;
    sov_next = so_prev_reg & ~sync_bus.set_overflow;
    // halt only takes effect on a read cycle; resumes on ready high
    if (!sync_bus.ready && i_cpu_read_cycle) begin
      halt_next = 1'b1;
    end else if (sync_bus.ready) begin
      halt_next = 1'b0;
    end else begin
      halt_next = halt_reg;
    end
    irq_next = ~sync_bus.irq_n;
    nmi_next = sync_bus.nmi_n;
    fl_next = floating;
    data_next = ~floating & ~i_onboard_selected;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rnw_reg <= 1'b0;
      syncout_reg <= 1'b0;
      bank_reg <= ~EBC_BANK_SEL_RESET;
      dmat_reg <= ~EBC_DMA_TERM_RESET;
      so_prev_reg <= 1'b1;
      sov_reg <= 1'b0;
      halt_reg <= 1'b0;
      irq_reg <= 1'b0;
      nmi_reg <= 1'b1;
      fl_reg <= 1'b0;
      data_reg <= 1'b0;
    end else begin
      rnw_reg <= rnw_next;
      syncout_reg <= syncout_next;
      bank_reg <= bank_next;
      dmat_reg <= dmat_next;
      so_prev_reg <= so_prev_next;
      sov_reg <= sov_next;
      halt_reg <= halt_next;
      irq_reg <= irq_next;
      nmi_reg <= nmi_next;
      fl_reg <= fl_next;
      data_reg <= data_next;
    end
  end

  assign o_bus_read_not_write_n = rnw_reg;
  assign o_bus_opcode_fetch_sync = syncout_reg;
  assign o_bus_read_not_write_n_oe = ~fl_reg;
  assign o_bus_opcode_fetch_sync_oe = ~fl_reg;
  assign o_bank_select_n = bank_reg;
  assign o_bank_select_n_oe = ~fl_reg;
  assign o_address_oe = ~fl_reg;
  assign o_data_oe = data_reg;
  // phase one, reset and dma terminate ignore float
  assign o_phase1_out = i_phase1;
  assign o_dma_terminate_n = dmat_reg;
  assign o_cpu_set_overflow = sov_reg;
  assign o_cpu_halt = halt_reg;
  assign o_irq_bus_source = irq_reg;
  assign o_cpu_nmi_n = nmi_reg;
  assign o_dma_active = fl_reg;

  // bus reset pulse generator; counter is wide enough for 10 ms at 100 MHz
  ebc_rst_state_e rst_state_reg, rst_state_next;
  logic [31:0] rst_count_reg, rst_count_next;
  logic busrst_reg, busrst_next;

  always_comb begin
    rst_state_next = rst_state_reg;
    rst_count_next = rst_count_reg;
    busrst_next = 1'b0;
    case (rst_state_reg)
      EBC_RST_POWERON: begin
        rst_count_next = rst_count_reg + 32'h0000_0001;
        // a press during the power-on pulse must still hold reset past its end
        if (sync_bus.button) begin
          rst_state_next = EBC_RST_HELD;
          rst_count_next = 32'h0000_0000;
        end else if (rst_count_reg >= 32'(RESET_CYCLES - 1)) begin
          rst_state_next = EBC_RST_IDLE;
          rst_count_next = 32'h0000_0000;
        end
      end
      EBC_RST_HELD: begin
        rst_count_next = 32'h0000_0000;
        if (!sync_bus.button) begin
          rst_state_next = EBC_RST_STRETCH;
        end
      end
      EBC_RST_STRETCH: begin
        rst_count_next = rst_count_reg + 32'h0000_0001;
        if (sync_bus.button) begin
          rst_state_next = EBC_RST_HELD;
        end else if (rst_count_reg >= 32'(RESET_CYCLES - 1)) begin
          rst_state_next = EBC_RST_IDLE;
          rst_count_next = 32'h0000_0000;
        end
      end
      default: begin
        busrst_next = 1'b1;
        rst_count_next = 32'h0000_0000;
        if (sync_bus.button) begin
          rst_state_next = EBC_RST_HELD;
          busrst_next = 1'b0;
        end
      end
    endcase
    if (rst_state_next == EBC_RST_IDLE && rst_state_reg != EBC_RST_IDLE) begin
      busrst_next = 1'b1;
    end
  end

  // i_rst models power-on
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rst_state_reg <= EBC_RST_POWERON;
      rst_count_reg <= 32'h0000_0000;
      busrst_reg <= 1'b0;
    end else begin
      rst_state_reg <= rst_state_next;
      rst_count_reg <= rst_count_next;
      busrst_reg <= busrst_next;
    end
  end

  assign o_bus_reset_n = busrst_reg;

  chk_float_release: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_bus_float_request_n [*3] |=> !o_bus_read_not_write_n_oe && !o_bus_opcode_fetch_sync_oe)
    else $error("read/write or sync driven during float");
  chk_rnw_inverse: assert property (@(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |-> o_bus_read_not_write_n == !$past(i_cpu_read_write))
    else $error("read/write not inverted");
  chk_sync_fetch: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_cpu_sync && i_phase1) |=> o_bus_opcode_fetch_sync)
    else $error("sync missing on fetch");
  chk_overflow_edge: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(sync_bus.set_overflow) |=> o_cpu_set_overflow)
    else $error("overflow not set");
  chk_ready_halt: assert property (@(posedge i_clock) disable iff (i_rst)
    (sync_bus.ready) |=> !o_cpu_halt)
    else $error("halt held with ready high");
  chk_dma_term: assert property (@(posedge i_clock) disable iff (i_rst)
    i_dma_terminate_ctrl_bit |=> !o_dma_terminate_n)
    else $error("dma terminate not driven");
  chk_irq_route: assert property (@(posedge i_clock) disable iff (i_rst)
    !sync_bus.irq_n |=> o_irq_bus_source)
    else $error("bus irq lost");
  chk_nmi_route: assert property (@(posedge i_clock) disable iff (i_rst)
    !sync_bus.nmi_n |=> !o_cpu_nmi_n)
    else $error("nmi lost");
  chk_reset_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    sync_bus.button |=> !o_bus_reset_n)
    else $error("bus reset released while button pressed");
  chk_bank_level: assert property (@(posedge i_clock) disable iff (i_rst)
    i_bank_select_ctrl_bit |=> !o_bank_select_n)
    else $error("bank select wrong");
  chk_data_off: assert property (@(posedge i_clock) disable iff (i_rst)
    i_onboard_selected |=> !o_data_oe)
    else $error("data transceiver on for on-board access");

  cov_float: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_dma_active));
  cov_reset_done: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_bus_reset_n));
  cov_halt: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_cpu_halt));
endmodule

/* File: hw/ebc_pkg.sv */
// package for the expansion bus control block
// assumes a 100 MHz processor clock
package ebc_pkg;
  localparam int unsigned EBC_CLOCK_MHZ = 100;
  localparam int unsigned EBC_RESET_PULSE_MS = 10;
  localparam int unsigned EBC_RESET_CYCLES = EBC_RESET_PULSE_MS * 1000 * EBC_CLOCK_MHZ;
  localparam int unsigned EBC_SYNC_STAGES = 2;
  localparam logic EBC_BANK_SEL_RESET = 1'b0;
  localparam logic EBC_DMA_TERM_RESET = 1'b0;
  typedef enum logic [1:0] {
    EBC_RST_POWERON,
    EBC_RST_HELD,
    EBC_RST_STRETCH,
    EBC_RST_IDLE
  } ebc_rst_state_e;
endpackage

/* File: hw/ebc_sync_if.sv */
// interface carrying synchronised bus inputs from the synchroniser
// assumes one clock domain
`timescale 1ns/1ns
interface ebc_sync_if;
  logic ready;
  logic set_overflow;
  logic float_n;
  logic irq_n;
  logic nmi_n;
  logic button;
  modport src (output ready, output set_overflow, output float_n, output irq_n, output nmi_n,
    output button);
  modport dst (input ready, input set_overflow, input float_n, input irq_n, input nmi_n,
    input button);
endinterface

/* File: hw/ebc_input_sync.sv */
// two-flop synchronisers for the asynchronous bus inputs
// assumes inputs come straight from pins; idle levels are high except the reset button, which idles low
`timescale 1ns/1ns
module ebc_input_sync
  import ebc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [5:0] i_async,
  ebc_sync_if.src sync_out
);
  logic [5:0] stage1_reg;
  logic [5:0] stage2_reg;
  logic [5:0] stage1_next;
  logic [5:0] stage2_next;

  always_comb begin
    stage1_next = i_async;
    stage2_next = stage1_reg;
  end

  // reset to idle (all high, except button released)
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      stage1_reg <= 6'h1f;
      stage2_reg <= 6'h1f;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out.ready = stage2_reg[0];
  assign sync_out.set_overflow = stage2_reg[1];
  assign sync_out.float_n = stage2_reg[2];
  assign sync_out.irq_n = stage2_reg[3];
  assign sync_out.nmi_n = stage2_reg[4];
  assign sync_out.button = stage2_reg[5];
endmodule

/* File: tb/ebc_bus_partner.sv */
// bus-side model: plug-in modules and a dma master on the shared lines
// assumes open-collector lines pulled high; commands arrive at falling edges
// lines move on rising edges by nonblocking assignment, so no race with the bench
`timescale 1ns/1ns
module ebc_bus_partner (
  input wire logic i_clock,
  input wire logic i_want_bus,
  input wire logic i_want_irq,
  input wire logic i_want_nmi,
  input wire logic i_stall,
  input wire logic i_overflow,
  input wire logic i_dma_terminate_n,
  output logic o_bus_float_request_n,
  output logic o_bus_irq_n,
  output logic o_bus_nmi_n,
  output logic o_bus_ready_in,
  output logic o_bus_set_overflow
);
  logic stopped_reg;
  initial begin
    stopped_reg = 1'h0;
    o_bus_float_request_n = 1'h1;
    o_bus_irq_n = 1'h1;
    o_bus_nmi_n = 1'h1;
    o_bus_ready_in = 1'h1;
    o_bus_set_overflow = 1'h1;
  end
  // released lines go to the pull-up level, never hold a stale value
  always @(posedge i_clock) begin
    // once terminated the master stays off until it drops its own request
    if (!i_want_bus) begin
      stopped_reg <= 1'h0;
    end else if (!i_dma_terminate_n) begin
      stopped_reg <= 1'h1;
    end
    o_bus_float_request_n <= !(i_want_bus && i_dma_terminate_n && !stopped_reg);
    o_bus_irq_n <= !i_want_irq;
    o_bus_nmi_n <= !i_want_nmi;
    o_bus_ready_in <= !i_stall;
    o_bus_set_overflow <= !i_overflow;
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the expansion bus control block
// assumes a short reset stretch parameter; inputs change at falling edges
`timescale 1ns/1ns
module testbench;
  import ebc_pkg::*;
  localparam int unsigned RST_CY = 20;
  logic clk, rst, rw, csync, ph1, rdc, onb, bank, dmab, btn;
  logic want_bus, want_irq, want_nmi, stall, ovf;
  logic flt_n, irq_n, nmi_n, rdy, so;
  logic rnw_n, rnw_oe, syn, syn_oe, bank_n, bank_oe, adr_oe, dat_oe, ph1_o;
  logic dmat_n, bus_rst_n, cpu_so, halt, irq_src, cpu_nmi_n, dma_act;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int pulses;
  ebc_bus_control #(.RESET_CYCLES(RST_CY)) u_ebc_bus_control (.i_clock(clk), .i_rst(rst),
    .i_cpu_read_write(rw), .i_cpu_sync(csync), .i_phase1(ph1), .i_cpu_read_cycle(rdc),
    .i_onboard_selected(onb), .i_bank_select_ctrl_bit(bank), .i_dma_terminate_ctrl_bit(dmab),
    .i_reset_button(btn), .i_bus_set_overflow(so), .i_bus_ready_in(rdy),
    .i_bus_float_request_n(flt_n), .i_bus_irq_n(irq_n), .i_bus_nmi_n(nmi_n),
    .o_bus_read_not_write_n(rnw_n), .o_bus_read_not_write_n_oe(rnw_oe),
    .o_bus_opcode_fetch_sync(syn), .o_bus_opcode_fetch_sync_oe(syn_oe),
    .o_bank_select_n(bank_n), .o_bank_select_n_oe(bank_oe), .o_address_oe(adr_oe),
    .o_data_oe(dat_oe), .o_phase1_out(ph1_o), .o_dma_terminate_n(dmat_n),
    .o_bus_reset_n(bus_rst_n), .o_cpu_set_overflow(cpu_so), .o_cpu_halt(halt),
    .o_irq_bus_source(irq_src), .o_cpu_nmi_n(cpu_nmi_n), .o_dma_active(dma_act));
  ebc_bus_partner u_ebc_bus_partner (.i_clock(clk), .i_want_bus(want_bus),
    .i_want_irq(want_irq), .i_want_nmi(want_nmi), .i_stall(stall), .i_overflow(ovf),
    .i_dma_terminate_n(dmat_n), .o_bus_float_request_n(flt_n), .o_bus_irq_n(irq_n),
    .o_bus_nmi_n(nmi_n), .o_bus_ready_in(rdy), .o_bus_set_overflow(so));
  initial begin
    clk = 1'h0;
    forever #5 clk = !clk;
  end
  task check(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // cycle ceiling well above the sum of all scenarios
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up;
    end
  end
  task t_power_on;
    step(RST_CY - 2);
    check(bus_rst_n, 1'h0);
    step(8);
    check(bus_rst_n, 1'h1);
  endtask
  task t_levels;
    rw = 1'h1; bank = 1'h1; dmab = 1'h1;
    step(2);
    check(rnw_n, 1'h0);
    check(bank_n, 1'h0);
    check(dmat_n, 1'h0);
    rw = 1'h0; bank = 1'h0; dmab = 1'h0;
    step(2);
    check(rnw_n, 1'h1);
    check(bank_n, 1'h1);
    check(dmat_n, 1'h1);
    onb = 1'h1;
    step(2);
    check(dat_oe, 1'h0);
    check(adr_oe, 1'h1);
    onb = 1'h0;
  endtask
  task t_sync;
    csync = 1'h1; ph1 = 1'h1;
    #1 check(ph1_o, 1'h1);
    step(2);
    check(syn, 1'h1);
    csync = 1'h0; ph1 = 1'h0;
    step(2);
    check(syn, 1'h1);
    ph1 = 1'h1;
    step(2);
    check(syn, 1'h0);
  endtask
  task t_float;
    want_bus = 1'h1;
    step(5);
    check(dma_act, 1'h1);
    check(rnw_oe, 1'h0);
    check(syn_oe, 1'h0);
    check(bank_oe, 1'h0);
    check(adr_oe, 1'h0);
    check(dat_oe, 1'h0);
    check(bus_rst_n, 1'h1);
    ph1 = 1'h0;
    #1 check(ph1_o, 1'h0);
    dmab = 1'h1;
    step(2);
    check(dmat_n, 1'h0);
    step(5);
    check(dma_act, 1'h0);
    check(rnw_oe, 1'h1);
    want_bus = 1'h0; dmab = 1'h0;
    step(5);
  endtask
  task t_interrupts;
    want_irq = 1'h1; want_nmi = 1'h1;
    step(5);
    check(irq_src, 1'h1);
    check(cpu_nmi_n, 1'h0);
    want_irq = 1'h0; want_nmi = 1'h0;
    step(5);
    check(irq_src, 1'h0);
    check(cpu_nmi_n, 1'h1);
  endtask
  task t_ready;
    rdc = 1'h0; stall = 1'h1;
    step(5);
    check(halt, 1'h0);
    rdc = 1'h1;
    step(2);
    check(halt, 1'h1);
    stall = 1'h0;
    step(5);
    check(halt, 1'h0);
  endtask
  task t_overflow;
    pulses = 0;
    ovf = 1'h1;
    repeat (8) begin
      step(1);
      if (cpu_so === 1'h1) pulses++;
    end
    check(pulses == 1, 1'h1);
    pulses = 0;
    ovf = 1'h0;
    repeat (8) begin
      step(1);
      if (cpu_so === 1'h1) pulses++;
    end
    check(pulses == 0, 1'h1);
  endtask
  task t_button;
    btn = 1'h1;
    step(4);
    check(bus_rst_n, 1'h0);
    step(RST_CY + 10);
    check(bus_rst_n, 1'h0);
    btn = 1'h0;
    step(RST_CY - 2);
    check(bus_rst_n, 1'h0);
    step(8);
    check(bus_rst_n, 1'h1);
  endtask
  initial begin
    rst = 1'h1; rw = 1'h0; csync = 1'h0; ph1 = 1'h0; rdc = 1'h0; onb = 1'h0;
    bank = 1'h0; dmab = 1'h0; btn = 1'h0; want_bus = 1'h0; want_irq = 1'h0;
    want_nmi = 1'h0; stall = 1'h0; ovf = 1'h0;
    step(16);
    rst = 1'h0;
    t_power_on();
    t_levels();
    t_sync();
    t_float();
    t_interrupts();
    t_ready();
    t_overflow();
    t_button();
    wrap_up();
  end
endmodule
